// >>> hw/dbc_regs.svh
/*
 * Constants for the disk buffer cache controller: mode page field
 * positions, fixed reported values, buffer sizing and command codes.
 * Assumes inclusion by bare name from the design.
 */
`ifndef DBC_REGS_SVH
`define DBC_REGS_SVH

// ---------------------------------------------------------------------
// Register offsets on the plain register port
// ---------------------------------------------------------------------
`define DBC_OFS_CACHE_CFG    4'h0
`define DBC_OFS_SEG_COUNT    4'h1
`define DBC_OFS_SEG_SIZE     4'h2
`define DBC_OFS_MAX_PREFETCH 4'h3
`define DBC_OFS_CEILING      4'h4
`define DBC_OFS_STATUS       4'h5
`define DBC_OFS_SEG_LEN      4'h6

// ---------------------------------------------------------------------
// Field positions inside the config register
// ---------------------------------------------------------------------
`define DBC_BIT_RCD          0
`define DBC_BIT_PARAM_CHECK  1
`define DBC_BIT_WCE          2
`define DBC_BIT_DISC         4
`define DBC_BIT_DRA          5

// ---------------------------------------------------------------------
// Reset values and fixed answers
// ---------------------------------------------------------------------
`define DBC_RST_CFG          8'h00
`define DBC_RST_SEG_COUNT    5'h01
`define DBC_RST_MAX_PREFETCH 16'hFFFF
`define DBC_SEG_SIZE_REPORT  16'hFFFF
`define DBC_SEG_COUNT_MAX    5'h10
`define DBC_RESERVED_KB      100

// ---------------------------------------------------------------------
// Host command codes
// ---------------------------------------------------------------------
`define DBC_CMD_READ         2'h0
`define DBC_CMD_WRITE        2'h1
`define DBC_CMD_SYNC         2'h2
`define DBC_CMD_STOP         2'h3

`endif

// >>> hw/dbc_pkg.sv
/*
 * Types shared by the disk buffer cache controller.
 * Assumes the constants header sits beside it.
 */
package dbc_pkg;

    // Host command as handed over by the command decoder
    typedef struct packed {
        logic [1:0]  op;
        logic [31:0] lba;
        logic [15:0] count;
    } dbc_cmd_t;

    // Medium job request towards the read/write channel
    typedef struct packed {
        logic        wr;
        logic [31:0] lba;
        logic [15:0] count;
        logic [3:0]  seg;
    } dbc_media_t;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'b000_0001,
        ST_LOOKUP  = 7'b000_0010,
        ST_HIT     = 7'b000_0100,
        ST_MEDIA   = 7'b000_1000,
        ST_WRITE   = 7'b001_0000,
        ST_FLUSH   = 7'b010_0000,
        ST_DONE    = 7'b100_0000
    } dbc_state_t;

endpackage

// >>> hw/dbc_cache_ctrl.sv
/*
 * Segmented buffer cache controller: serves host reads from cached or
 * prefetched blocks, falls back to medium jobs, caches writes, flushes.
 * Assumes a command decoder on the host side handing one command at a
 * time, and a medium channel that acknowledges each job with done/err.
 */
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "dbc_regs.svh"

module dbc_cache_ctrl
    import dbc_pkg::*;
#(
    parameter int BUF_KB       = 1024,
    parameter int SECTOR_BYTES = 512,
    parameter int NSEG         = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             reg_reject,
    // Host command side
    input  wire logic        cmd_valid,
    input  wire dbc_cmd_t    cmd,
    output logic             cmd_ready,
    output logic             status_good,
    output logic             status_err,
    output logic             deferred_err,
    output logic             queue_slot_busy,
    output logic             xfer_paced,
    output logic [15:0]      hit_blocks,
    output logic             stopped,
    // Medium side
    output logic             media_req,
    output dbc_media_t       media_job,
    input  wire logic        media_done,
    input  wire logic        media_err,
    input  wire logic        cyl_boundary
);

    // -----------------------------------------------------------------
    // Sizing
    // -----------------------------------------------------------------
    // reserved space excluded
    localparam int USABLE_SECT = ((BUF_KB - `DBC_RESERVED_KB) * 1024) / SECTOR_BYTES;

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    logic [7:0]  cfg_ff;
    logic [4:0]  seg_count_ff;
    logic [15:0] max_pf_ff;
    logic [15:0] ceiling_ff;
    logic        reg_reject_ff;
    logic [15:0] seg_len_ff;

    wire read_cache_disable = cfg_ff[`DBC_BIT_RCD];
    wire param_check_a      = cfg_ff[`DBC_BIT_PARAM_CHECK];
    wire write_cache_enable = cfg_ff[`DBC_BIT_WCE];
    wire disc_flag          = cfg_ff[`DBC_BIT_DISC];
    wire read_ahead_disable = cfg_ff[`DBC_BIT_DRA];

    // Software writes; size writes store nothing and are refused when parameter checking is on
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_ff        <= `DBC_RST_CFG;
            seg_count_ff  <= `DBC_RST_SEG_COUNT;
            max_pf_ff     <= `DBC_RST_MAX_PREFETCH;
            ceiling_ff    <= 16'h0000;
            reg_reject_ff <= 1'b0;
        end else begin
            reg_reject_ff <= 1'b0;
            if (reg_wr) begin
                unique case (reg_addr)
                    `DBC_OFS_CACHE_CFG:    cfg_ff <= reg_wdata[7:0];
                    `DBC_OFS_SEG_COUNT: begin
                        if (reg_wdata[4:0] != 5'h00 && reg_wdata <= 16'h0010)
                            seg_count_ff <= reg_wdata[4:0];
                        else
                            reg_reject_ff <= 1'b1;
                    end
                    `DBC_OFS_SEG_SIZE:     reg_reject_ff <= param_check_a;
                    `DBC_OFS_MAX_PREFETCH: max_pf_ff <= reg_wdata;
                    `DBC_OFS_CEILING:      ceiling_ff <= reg_wdata;
                    default:               reg_reject_ff <= 1'b0;
                endcase
            end
        end
    end
    assign reg_reject = reg_reject_ff;

    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            seg_len_ff <= 16'h0001;
        else
            seg_len_ff <= 16'(USABLE_SECT / int'(seg_count_ff));
    end

    // -----------------------------------------------------------------
    // Segment lookup table
    // -----------------------------------------------------------------
    logic [NSEG-1:0] seg_valid_ff;
    logic [31:0]     seg_lba_ff [NSEG];
    logic [15:0]     seg_cnt_ff [NSEG];
    logic [NSEG-1:0] seg_hit;
    logic [NSEG-1:0] seg_overlap;
    logic [31:0]     probe_lba_ff;
    logic [31:0]     wr_end;

    for (genvar g = 0; g < NSEG; g++) begin : g_seg
        wire active = (5'(g) < seg_count_ff) && seg_valid_ff[g];
        assign seg_hit[g] = active && probe_lba_ff >= seg_lba_ff[g]
                            && probe_lba_ff < seg_lba_ff[g] + 32'(seg_cnt_ff[g]);
        assign seg_overlap[g] = active && cmd.lba < seg_lba_ff[g] + 32'(seg_cnt_ff[g])
                                && wr_end > seg_lba_ff[g];
    end
    assign wr_end = cmd.lba + 32'(cmd.count);

    // -----------------------------------------------------------------
    // Command sequencer
    // -----------------------------------------------------------------
    dbc_state_t  state_ff;
    dbc_cmd_t    cur_ff;
    logic [15:0] left_ff;
    logic [3:0]  ring_ff;           // Next segment to recycle
    logic [3:0]  job_seg_ff;
    logic        job_wr_ff;
    logic        early_good_ff;
    logic [15:0] dirty_ff;          // Writes with uncommitted data
    logic        status_good_ff;
    logic        status_err_ff;
    logic        deferred_ff;
    logic        media_req_ff;
    logic        paced_ff;
    logic [15:0] hit_blocks_ff;
    logic        stopped_ff;
    logic [31:0] last_end_ff;
    logic [31:0] prev_start_ff;
    logic        pf_on_ff;
    logic        pf_job_ff;
    logic [15:0] pf_len;
    logic        contiguous;
    logic        interleave;

    assign contiguous = cur_ff.lba == last_end_ff;
    assign interleave = (cur_ff.lba > last_end_ff)
                        && (cur_ff.lba - last_end_ff == last_end_ff - prev_start_ff
                            - 32'(cur_ff.count));
    // cap at max prefetch and segment
    assign pf_len = (max_pf_ff < seg_len_ff) ? max_pf_ff : seg_len_ff;

    assign cmd_ready = (state_ff == ST_IDLE);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff       <= ST_IDLE;
            cur_ff         <= '0;
            left_ff        <= 16'h0000;
            ring_ff        <= 4'h0;
            job_seg_ff     <= 4'h0;
            job_wr_ff      <= 1'b0;
            early_good_ff  <= 1'b0;
            status_good_ff <= 1'b0;
            status_err_ff  <= 1'b0;
            media_req_ff   <= 1'b0;
            paced_ff       <= 1'b0;
            hit_blocks_ff  <= 16'h0000;
            stopped_ff     <= 1'b0;
            probe_lba_ff   <= 32'h0000_0000;
            pf_job_ff      <= 1'b0;
        end else begin
            status_good_ff <= 1'b0;
            status_err_ff  <= 1'b0;
            media_req_ff   <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        cur_ff        <= cmd;
                        left_ff       <= cmd.count;
                        probe_lba_ff  <= cmd.lba;
                        hit_blocks_ff <= 16'h0000;
                        paced_ff      <= 1'b0;
                        unique case (cmd.op)
                            `DBC_CMD_READ: begin
                                stopped_ff <= 1'b0;
                                state_ff <= read_cache_disable ? ST_MEDIA : ST_LOOKUP;
                            end
                            `DBC_CMD_WRITE: begin
                                stopped_ff <= 1'b0;
                                state_ff   <= ST_WRITE;
                            end
                            `DBC_CMD_SYNC: state_ff <= ST_FLUSH;
                            default:       state_ff <= ST_FLUSH;
                        endcase
                    end
                end
                ST_LOOKUP: begin
                    state_ff <= (|seg_hit) ? ST_HIT : ST_MEDIA;
                end
                ST_HIT: begin
                    if (left_ff == 16'h0000) begin
                        state_ff <= ST_DONE;
                    end else if (|seg_hit) begin
                        probe_lba_ff  <= probe_lba_ff + 32'h0000_0001;
                        left_ff       <= left_ff - 16'h0001;
                        hit_blocks_ff <= hit_blocks_ff + 16'h0001;
                    end else begin
                        state_ff <= ST_MEDIA;
                    end
                end
                ST_MEDIA: begin
                    if (!media_req_ff && !job_wr_ff && job_seg_ff == ring_ff && left_ff != 0
                        && !paced_ff) begin
                        media_req_ff <= 1'b1;
                        paced_ff     <= 1'b1;
                    end else if (!paced_ff && left_ff == 16'h0000) begin
                        state_ff <= ST_DONE;
                    end
                    job_seg_ff <= ring_ff;
                    job_wr_ff  <= 1'b0;
                    if (media_done && paced_ff) begin
                        left_ff  <= 16'h0000;
                        ring_ff  <= 5'(ring_ff) + 5'h01 >= seg_count_ff ? 4'h0 : ring_ff + 4'h1;
                        state_ff <= ST_DONE;
                    end
                end
                ST_WRITE: begin
                    if (!paced_ff) begin
                        media_req_ff <= 1'b1;
                        paced_ff     <= 1'b1;
                        job_wr_ff    <= 1'b1;
                        job_seg_ff   <= ring_ff;
                        early_good_ff <= write_cache_enable;
                        if (write_cache_enable)
                            status_good_ff <= 1'b1;
                    end else if (media_done) begin
                        ring_ff  <= 5'(ring_ff) + 5'h01 >= seg_count_ff ? 4'h0 : ring_ff + 4'h1;
                        job_wr_ff <= 1'b0;
                        state_ff <= early_good_ff ? ST_IDLE : ST_DONE;
                        status_err_ff <= media_err && !early_good_ff;
                    end
                end
                ST_FLUSH: begin
                    if (dirty_ff == 16'h0000 && !media_req_ff) begin
                        status_good_ff <= 1'b1;
                        stopped_ff     <= (cur_ff.op == `DBC_CMD_STOP);
                        state_ff       <= ST_IDLE;
                    end
                end
                ST_DONE: begin
                    status_good_ff <= !status_err_ff;
                    state_ff       <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Table maintenance
    // -----------------------------------------------------------------
    // one ring per segment, sector length
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seg_valid_ff <= '0;
            for (int i = 0; i < NSEG; i++) begin
                seg_lba_ff[i] <= 32'h0000_0000;
                seg_cnt_ff[i] <= 16'h0000;
            end
        end else if (state_ff == ST_IDLE && cmd_valid && cmd.op == `DBC_CMD_WRITE
                     && !read_cache_disable) begin
            seg_valid_ff <= seg_valid_ff & ~seg_overlap;
        end else if (media_req_ff) begin
            seg_valid_ff[ring_ff] <= !(job_wr_ff && read_cache_disable);
            seg_lba_ff[ring_ff]   <= media_job.lba;
            seg_cnt_ff[ring_ff]   <= media_job.count > seg_len_ff ? seg_len_ff
                                                                  : media_job.count;
        end
    end

    // Medium job assembly with prefetch tail
    always_comb begin
        media_job       = '0;
        media_job.wr    = job_wr_ff;
        media_job.lba   = cur_ff.lba + 32'(cur_ff.count - left_ff);
        media_job.count = left_ff;
        media_job.seg   = ring_ff;
        // prefetch beyond read, cache or not
        if (!job_wr_ff && !read_ahead_disable && pf_on_ff
            && (disc_flag || !cyl_boundary))
            media_job.count = left_ff + pf_len;
        if (job_wr_ff)
            media_job.lba = cur_ff.lba;
        if (job_wr_ff)
            media_job.count = cur_ff.count;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            last_end_ff   <= 32'h0000_0000;
            prev_start_ff <= 32'h0000_0000;
            pf_on_ff      <= 1'b1;
        end else if (state_ff == ST_LOOKUP || (state_ff == ST_MEDIA && !paced_ff
                     && left_ff == cur_ff.count && read_cache_disable)) begin
            pf_on_ff      <= contiguous || interleave;
            prev_start_ff <= cur_ff.lba;
            last_end_ff   <= cur_ff.lba + 32'(cur_ff.count);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            dirty_ff <= 16'h0000;
        else if (status_good_ff && state_ff == ST_WRITE && !(media_done && job_wr_ff))
            dirty_ff <= dirty_ff + 16'h0001;
        else if (media_done && job_wr_ff && early_good_ff && dirty_ff != 0)
            dirty_ff <= dirty_ff - 16'h0001;
    end

    // deferred error, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            deferred_ff <= 1'b0;
        else if (media_done && media_err && job_wr_ff && early_good_ff)
            deferred_ff <= 1'b1;
        else if (reg_rd && reg_addr == `DBC_OFS_STATUS)
            deferred_ff <= 1'b0;
    end

    // -----------------------------------------------------------------
    // Read side of the register port
    // -----------------------------------------------------------------
    logic [15:0] nxt_rdata;
    logic [15:0] rdata_ff;
    always_comb begin
        unique case (reg_addr)
            `DBC_OFS_CACHE_CFG:    nxt_rdata = {8'h00, cfg_ff};
            `DBC_OFS_SEG_COUNT:    nxt_rdata = {11'h000, seg_count_ff};
            `DBC_OFS_SEG_SIZE:     nxt_rdata = `DBC_SEG_SIZE_REPORT;
            `DBC_OFS_MAX_PREFETCH: nxt_rdata = max_pf_ff;
            `DBC_OFS_CEILING:      nxt_rdata = ceiling_ff;
            `DBC_OFS_STATUS:       nxt_rdata = {13'h0000, stopped_ff, pf_on_ff, deferred_ff};
            `DBC_OFS_SEG_LEN:      nxt_rdata = seg_len_ff;
            default:               nxt_rdata = 16'h0000;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            rdata_ff <= 16'h0000;
        else
            rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
    end

    // Outputs
    assign reg_rdata       = rdata_ff;
    assign status_good     = status_good_ff;
    assign status_err      = status_err_ff;
    assign deferred_err    = deferred_ff;
    assign queue_slot_busy = dirty_ff != 16'h0000;
    assign xfer_paced      = paced_ff;
    assign hit_blocks      = hit_blocks_ff;
    assign stopped         = stopped_ff;
    assign media_req       = media_req_ff;

endmodule

// >>> tb/dbc_media_model.sv
/* Medium channel model: finishes each job after a settable delay.
   Assumes one job outstanding, each requested by a one-cycle pulse. */
`timescale 1ns/1ps
module dbc_media_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       media_req,
    input  wire logic       fail,
    input  wire logic [7:0] dly,
    output logic            media_done,
    output logic            media_err
);
    logic [7:0] cnt_ff;
    // Job countdown; error flag only beside done
    always_ff @(posedge clk_sys) begin
        if (!rst_n || media_req) begin
            cnt_ff <= media_req ? dly : 8'h00;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
        media_done <= rst_n && cnt_ff == 8'h01;
        media_err  <= rst_n && cnt_ff == 8'h01 && fail;
    end
endmodule

// >>> tb/dbc_cache_monitor.sv
/* Port checker for the cache controller, bound into the design.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module dbc_cache_monitor
    import dbc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_reject,
    input wire logic        cmd_valid,
    input wire dbc_cmd_t    cmd,
    input wire logic        cmd_ready,
    input wire logic        status_good,
    input wire logic        deferred_err,
    input wire logic        queue_slot_busy,
    input wire logic        stopped,
    input wire logic        media_req,
    input wire logic        media_done,
    input wire logic        media_err
);
    logic [7:0] cfg_ff;
    logic [1:0] op_ff;
    wire        take = cmd_valid && cmd_ready;
    // Shadow of config and of the command in flight
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_ff <= 8'h00;
            op_ff  <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == 4'h0) cfg_ff <= reg_wdata[7:0];
            if (take) op_ff <= cmd.op;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_wr_taken;
        take && cmd.op == 2'h1 && cfg_ff[2];
    endsequence
    sequence s_rd_nocache;
        take && cmd.op == 2'h0 && cfg_ff[0] && |cmd.count;
    endsequence
    AST_SEG_SIZE: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata == 16'hFFFF)
        else $error("segment size read back wrong");
    AST_BAD_COUNT: assert property (reg_wr && reg_addr == 4'h1 &&
        !(reg_wdata inside {[16'h0001:16'h0010]}) |=> reg_reject) else $error("bad count taken");
    AST_GOOD_COUNT: assert property (reg_wr && reg_addr == 4'h1 &&
        reg_wdata inside {[16'h0001:16'h0010]} |=> !reg_reject) else $error("good count refused");
    AST_REJ_CAUSE: assert property (reg_reject |-> $past(reg_wr) &&
        $past(reg_addr) inside {4'h1, 4'h2}) else $error("refusal without cause");
    AST_EARLY_GOOD: assert property (s_wr_taken |=> ##1 (status_good && media_req))
        else $error("no early good status");
    AST_SYNC_CLEAN: assert property (status_good && op_ff == 2'h2 |-> !queue_slot_busy)
        else $error("sync done with dirty data");
    AST_STOP_CLEAN: assert property ($rose(stopped) |-> !queue_slot_busy)
        else $error("stopped with dirty data");
    AST_DEFERRED: assert property (media_done && media_err && op_ff == 2'h1 && cfg_ff[2]
        |-> ##[1:2] deferred_err) else $error("no deferred error");
    AST_NOCACHE_MISS: assert property (s_rd_nocache |-> ##[1:4] media_req)
        else $error("uncached read skipped medium");
endmodule
bind dbc_cache_ctrl dbc_cache_monitor u_dbc_cache_monitor (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_reject(reg_reject),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .status_good(status_good),
    .deferred_err(deferred_err), .queue_slot_busy(queue_slot_busy), .stopped(stopped),
    .media_req(media_req), .media_done(media_done), .media_err(media_err));

// >>> tb/testbench.sv
/* Self-checking bench for the cache controller with a medium model.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
module testbench;
    import dbc_pkg::*;
    logic       clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic       cmd_valid = 1'b0, fail = 1'b0, reg_reject, cmd_ready, status_good, cyl = 1'b0;
    logic       status_err, deferred_err, queue_slot_busy, xfer_paced, stopped;
    logic       media_req, media_done, media_err, good, paced;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] dly = 8'h03;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, hit_blocks;
    dbc_cmd_t   cmd = '0;
    dbc_media_t media_job, job;
    int         fail_count = 0, comparisons = 0, jobs;
    dbc_cache_ctrl #(.BUF_KB(1024), .SECTOR_BYTES(512), .NSEG(16)) u_dbc_cache_ctrl (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_reject(reg_reject),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .status_good(status_good),
        .status_err(status_err), .deferred_err(deferred_err), .stopped(stopped),
        .queue_slot_busy(queue_slot_busy), .xfer_paced(xfer_paced), .hit_blocks(hit_blocks),
        .media_req(media_req), .media_job(media_job), .media_done(media_done),
        .media_err(media_err), .cyl_boundary(cyl));
    dbc_media_model u_dbc_media_model (.clk_sys(clk_sys), .rst_n(rst_n), .media_req(media_req),
        .fail(fail), .dly(dly), .media_done(media_done), .media_err(media_err));
    always #10 clk_sys = ~clk_sys;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Register port: strobe one cycle, answer sampled one edge later
    task automatic rg(input logic w, input logic [3:0] a, input logic [15:0] d,
                      output logic [15:0] q);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= !w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        q = w ? {15'h0000, reg_reject} : reg_rdata;
    endtask
    // Command: held until taken, then jobs watched until status
    task automatic run(input logic [1:0] op, input logic [31:0] lba, input logic [15:0] n);
        cmd       <= '{op: op, lba: lba, count: n};
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 300 && !cmd_ready; i++) @(posedge clk_sys);
        cmd_valid <= 1'b0;
        jobs  = 0;
        paced = 1'b0;
        for (int i = 0; i < 600 && !(status_good || status_err); i++) begin
            @(posedge clk_sys);
            if (media_req) job = media_job;
            jobs += int'(media_req);
            paced |= xfer_paced;
        end
        good = status_good;
    endtask
    task automatic t_regs();
        logic [15:0] q;
        // Per entry: write flag, index, data, expected refusal or read value
        logic [36:0] tb_tbl [17] = '{
            {1'b0, 4'h1, 16'h0000, 16'h0001}, {1'b0, 4'h2, 16'h0000, 16'hFFFF},
            {1'b0, 4'h3, 16'h0000, 16'hFFFF}, {1'b1, 4'h2, 16'h0040, 16'h0000},
            {1'b0, 4'h2, 16'h0000, 16'hFFFF}, {1'b1, 4'h0, 16'h0002, 16'h0000},
            {1'b1, 4'h2, 16'h0040, 16'h0001}, {1'b1, 4'h1, 16'h0000, 16'h0001},
            {1'b1, 4'h1, 16'h0011, 16'h0001}, {1'b1, 4'hF, 16'h0005, 16'h0000},
            {1'b0, 4'h1, 16'h0000, 16'h0001}, {1'b1, 4'h1, 16'h0010, 16'h0000},
            {1'b0, 4'h1, 16'h0000, 16'h0010}, {1'b0, 4'h6, 16'h0000, 16'h0073},
            {1'b1, 4'h1, 16'h0003, 16'h0000}, {1'b0, 4'h6, 16'h0000, 16'h0268},
            {1'b1, 4'h0, 16'h0000, 16'h0000}};
        // Segment length is (1024-100) KB of 512-byte sectors over the count
        foreach (tb_tbl[i]) begin
            rg(tb_tbl[i][36], tb_tbl[i][35:32], tb_tbl[i][31:16], q);
            chk(q, tb_tbl[i][15:0]);
        end
        $display("register test done");
    endtask
    task automatic t_traffic();
        logic [15:0] q;
        rg(1'b1, 4'h0, 16'h0021, q);
        run(2'h0, 32'h0000_0064, 16'h0004);
        chk({good, job.wr, job.lba[13:0], job.count}, {2'h2, 14'h0064, 16'h0004});
        chk(paced, 1'b1);
        dly <= 8'h14;
        rg(1'b1, 4'h0, 16'h0024, q);
        run(2'h1, 32'h0000_0064, 16'h0008);
        chk({good, job.wr, job.count}, {2'h3, 16'h0008});
        @(posedge clk_sys);
        chk(queue_slot_busy, 1'b1);
        run(2'h2, 32'h0000_0000, 16'h0000);
        chk({good, queue_slot_busy}, 2'h2);
        run(2'h0, 32'h0000_0064, 16'h0008);
        chk({jobs[3:0], paced, hit_blocks}, {5'h00, 16'h0008});
        run(2'h0, 32'h0000_0068, 16'h0008);
        chk({hit_blocks, job.lba[15:0]}, {16'h0004, 16'h006C});
        chk(job.count, 16'h0004);
        cyl <= 1'b1;
        rg(1'b1, 4'h0, 16'h0004, q);
        run(2'h0, 32'h0000_0070, 16'h0002);
        chk(job.count, 16'h0002);
        rg(1'b1, 4'h0, 16'h0014, q);
        run(2'h0, 32'h0000_0072, 16'h0002);
        chk({job.lba[15:0], job.count}, {16'h0072, 16'h026A});
        $display("traffic test done");
    endtask
    task automatic t_fault_stop();
        logic [15:0] q;
        rg(1'b1, 4'h0, 16'h0025, q);
        fail <= 1'b1;
        run(2'h1, 32'h0000_012C, 16'h0002);
        @(posedge clk_sys);
        for (int i = 0; i < 200 && queue_slot_busy; i++) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        fail <= 1'b0;
        chk(deferred_err, 1'b1);
        rg(1'b0, 4'h5, 16'h0000, q);
        chk({q[0], deferred_err}, 2'h2);
        dly <= 8'h28;
        run(2'h1, 32'h0000_0190, 16'h0002);
        run(2'h3, 32'h0000_0000, 16'h0000);
        @(posedge clk_sys);
        chk({good, stopped, queue_slot_busy}, 3'h6);
        rg(1'b1, 4'h0, 16'h0021, q);
        fail <= 1'b1;
        run(2'h1, 32'h0000_01F4, 16'h0002);
        chk({status_err, good}, 2'h2);
        $display("fault and stop test done");
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_traffic();
        t_fault_stop();
        close_out();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        close_out();
    end
endmodule
